// ===== verilog/sro_pkg.sv
package sro_pkg;
   localparam int CLK_NS = 20;
   localparam int POR_HOLD_NS = 1000;
   localparam int POR_HOLD_CYC = (POR_HOLD_NS + CLK_NS - 1) / CLK_NS;
   localparam int HOLD_W = 8;
   localparam logic [HOLD_W-1:0] POR_HOLD_CNT = HOLD_W'(POR_HOLD_CYC);
   localparam int DATA_W = 16;
   localparam int IDX_W = 16;
   localparam int REG_N = 17;
   typedef logic [IDX_W-1:0] sro_idx_t;
   localparam sro_idx_t REG_IDX [REG_N] = '{
      16'h0985, 16'h7010, 16'h7011, 16'h7012, 16'h7013, 16'h7014,
      16'h7016, 16'h701B, 16'h701C, 16'h701D, 16'h701E, 16'h7020,
      16'h7021, 16'h7022, 16'h7023, 16'h7025, 16'h7029};
   localparam int SLOT_BROWN = 0;
   localparam int SLOT_CLKSRC = 3;
   localparam int SLOT_OSC1TRIM = 5;
   localparam int SLOT_OSC2TRIM = 6;
   localparam int SLOT_STAT = 13;
   localparam int SLOT_WDCNT = 14;
   // status and counter slots are not writable from the bus
   localparam logic [REG_N-1:0] REG_WR = 17'h19FFF;
   localparam logic [DATA_W-1:0] REG_RST = 16'h0000;
   localparam int BROWN_DIS_BIT = 0;
   localparam int CLK_SEL_BIT = 0;
   localparam int OSC1_OFF_BIT = 1;
   localparam int OSC2_OFF_BIT = 2;
   localparam int STAT_UNLOCK_BIT = 0;
   localparam int STAT_STRAP_BIT = 1;
   localparam int STAT_PWR_BIT = 2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;
   localparam int SYNC_N = 7;
   localparam int SY_PORC = 0;
   localparam int SY_PORI = 1;
   localparam int SY_BORC = 2;
   localparam int SY_BORI = 3;
   localparam int SY_STRAP = 4;
   localparam int SY_PIN = 5;
   localparam int SY_CLK = 6;
   // monitors reset to "supply low", pin to "released"
   localparam logic [SYNC_N-1:0] SYNC_RST = 7'h2F;
endpackage : sro_pkg

// ===== verilog/sro_mon_if.sv
`timescale 1ns/100ps
interface sro_mon_if;
   logic porCoreLow;
   logic porIoLow;
   logic borCoreLow;
   logic borIoLow;
   logic borDisable;
   logic regDisable;
   logic supplyRst;
   logic powerUpDone;
   modport mon (input porCoreLow, porIoLow, borCoreLow, borIoLow,
      borDisable, regDisable, output supplyRst, powerUpDone);
   modport ctl (output porCoreLow, porIoLow, borCoreLow, borIoLow,
      borDisable, regDisable, input supplyRst, powerUpDone);
endinterface : sro_mon_if

// ===== verilog/sro_supply_mon.sv
`timescale 1ns/100ps
module sro_supply_mon import sro_pkg::*; (
   input wire logic sys_clk,
   input wire logic nrst,
   sro_mon_if.mon mon
);
   logic [HOLD_W-1:0] hold_q;
   logic done_q;
   logic rst_q;
   logic porTrip;
   logic borTrip;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   // power-on monitor never gated by strap or config
   assign porTrip = mon.porCoreLow || mon.porIoLow; // [R3]
   // brown-out only after first power-up; core rail only with regulator
   assign borTrip = done_q && !mon.borDisable &&
      (mon.borIoLow || (mon.borCoreLow && !mon.regDisable)); // [R4] [R6]

   ////////////////////////////////////////////////////////////////////
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         hold_q <= '0;
         done_q <= 1'b0;
      end else if (porTrip) begin
         hold_q <= '0;
         done_q <= 1'b0;
      end else if (hold_q != POR_HOLD_CNT) begin
         hold_q <= hold_q + 1'b1; // [R2]
      end else begin
         done_q <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         rst_q <= 1'b1;
      end else begin
         rst_q <= porTrip || !done_q || borTrip; // [R1] [R2]
      end
   end

   assign mon.supplyRst = rst_q;
   assign mon.powerUpDone = done_q;

   ////////////////////////////////////////////////////////////////////
   property p_por_trip;
      porTrip |=> rst_q;
   endproperty
   a_por_trip: assert property (p_por_trip) // [R3]
      else $error("power-on trip did not hold reset");

   property p_por_release;
      $fell(rst_q) |-> hold_q == POR_HOLD_CNT && !$past(porTrip);
   endproperty
   a_por_release: assert property (p_por_release) // [R2]
      else $error("reset released before power-up hold ended");

   property p_bor_disable;
      done_q && mon.borDisable && !porTrip |=> !rst_q;
   endproperty
   a_bor_disable: assert property (p_bor_disable) // [R6]
      else $error("brown-out still resets while disabled");

   property p_bor_core;
      done_q && !mon.borDisable && mon.borCoreLow && !mon.regDisable
         |=> rst_q;
   endproperty
   a_bor_core: assert property (p_bor_core) // [R4]
      else $error("core brown-out missed with regulator on");
endmodule : sro_supply_mon

// ===== verilog/sro_supply_reset_ctrl.sv
`timescale 1ns/100ps
// Behaviour
// R1: reset pin is driven low while any supply monitor sees a rail low.
// R2: power-on monitor holds reset through power-up until supplies valid.
// R3: power-on monitor watches core and I/O rails always, ungated.
// R4: brown-out watches I/O always, core only with regulator on.
// R5: regulator-disable pin is a static strap; low means regulator on.
// R6: one brown-out config bit disables brown-out on both rails.
// R7: after power-up both oscillators run and oscillator one is selected.
// R8: software may power down an oscillator that is not in use.
// R9: each oscillator's trim follows its own trim register.
// R10: cpu output clock runs at the cpu input clock frequency.
// R11: protected register writes are ignored unless unlocked first.
// R12: unlock lets writes through; lock blocks them again.
// R13: device reset is supply reset or watchdog reset, released when both low; code also asserts it while the reset pin reads low.
module sro_supply_reset_ctrl import sro_pkg::*; #(
   parameter int ADDR_W = 32
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic porCoreLowPin,
   input wire logic porIoLowPin,
   input wire logic borCoreLowPin,
   input wire logic borIoLowPin,
   input wire logic regulatorDisablePin,
   input wire logic deviceResetPinIn,
   output logic deviceResetPinOut,
   output logic deviceResetPinOe,
   input wire logic cpuInputClock,
   output logic cpuOutputClock,
   input wire logic watchdogReset,
   input wire logic writeProtectUnlock,
   input wire logic writeProtectLock,
   output logic deviceRst,
   output logic osc1Enable,
   output logic osc2Enable,
   output logic clkSrcSel,
   output logic [DATA_W-1:0] osc1Trim,
   output logic [DATA_W-1:0] osc2Trim
);
   logic [SYNC_N-1:0] pinsRaw;
   logic [SYNC_N-1:0] syncA_q;
   logic [SYNC_N-1:0] syncB_q;
   logic strap_q;
   logic unlocked_q;
   logic pinOut_q;
   logic pinOe_q;
   logic devRst_q;
   logic cpuOut_q;
   logic osc1En_q;
   logic osc2En_q;
   logic clkSel_q;
   logic [DATA_W-1:0] regs_q [REG_N];
   logic awReady_q;
   logic wReady_q;
   logic bValid_q;
   logic [1:0] bResp_q;
   logic [ADDR_W-1:0] awAddr_q;
   logic [DATA_W-1:0] wData_q;
   logic [1:0] wStrb_q;
   logic arReady_q;
   logic rValid_q;
   logic [1:0] rResp_q;
   logic [DATA_W-1:0] rData_q;
   logic awHs;
   logic wHs;
   logic arHs;
   logic wrFire;
   logic wrEn;
   logic [REG_N-1:0] wrHit;
   logic [REG_N-1:0] rdHit;
   logic [DATA_W-1:0] rdVal;
   logic [DATA_W-1:0] status;

   sro_mon_if monIf ();

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   function automatic logic [REG_N-1:0] decode(
      input logic [ADDR_W-1:0] a);
      logic [REG_N-1:0] hit;
      hit = '0;
      for (int i = 0; i < REG_N; i++) begin
         if (a[ADDR_W-1:IDX_W+2] == '0 && a[1:0] == 2'h0 &&
            a[IDX_W+1:2] == REG_IDX[i]) begin
            hit[i] = 1'b1;
         end
      end
      return hit;
   endfunction : decode

   ////////////////////////////////////////////////////////////////////
   // pin synchronisers: first stage feeds only the second
   assign pinsRaw = {cpuInputClock, deviceResetPinIn, regulatorDisablePin,
      borIoLowPin, borCoreLowPin, porIoLowPin, porCoreLowPin};

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         syncA_q <= SYNC_RST;
         syncB_q <= SYNC_RST;
      end else begin
         syncA_q <= pinsRaw;
         syncB_q <= syncA_q;
      end
   end

   ////////////////////////////////////////////////////////////////////
   assign monIf.porCoreLow = syncB_q[SY_PORC];
   assign monIf.porIoLow = syncB_q[SY_PORI];
   assign monIf.borCoreLow = syncB_q[SY_BORC];
   assign monIf.borIoLow = syncB_q[SY_BORI];
   assign monIf.borDisable = regs_q[SLOT_BROWN][BROWN_DIS_BIT]; // [R6]
   assign monIf.regDisable = strap_q;

   sro_supply_mon uMon (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .mon(monIf.mon)
   );

   // strap follows the pin only during power-up, frozen afterwards
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         strap_q <= 1'b0;
      end else if (!monIf.powerUpDone) begin
         strap_q <= syncB_q[SY_STRAP]; // [R5]
      end
   end

   // open-drain: output level fixed low, enable pulls the wire
   always_ff @(posedge sys_clk) begin
      pinOut_q <= 1'b0;
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         pinOe_q <= 1'b1;
      end else begin
         pinOe_q <= monIf.supplyRst; // [R1]
      end
   end

   // a board-level pull-down on the pin also resets the device
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         devRst_q <= 1'b1;
      end else begin
         devRst_q <= monIf.supplyRst || watchdogReset ||
            !syncB_q[SY_PIN]; // [R13]
      end
   end

   // input clock must be well below sys_clk; edges are delayed 3 cycles
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         cpuOut_q <= 1'b0;
      end else begin
         cpuOut_q <= syncB_q[SY_CLK]; // [R10]
      end
   end

   // lock wins when both arrive together, the safer outcome
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         unlocked_q <= 1'b0;
      end else if (writeProtectLock) begin
         unlocked_q <= 1'b0; // [R12]
      end else if (writeProtectUnlock) begin
         unlocked_q <= 1'b1; // [R12]
      end
   end

   ////////////////////////////////////////////////////////////////////
   assign awHs = s_axi_awvalid && awReady_q;
   assign wHs = s_axi_wvalid && wReady_q;
   assign arHs = s_axi_arvalid && arReady_q;
   assign wrFire = !awReady_q && !wReady_q && !bValid_q;
   assign wrHit = decode(awAddr_q);
   assign wrEn = wrFire && unlocked_q; // [R11]

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         awReady_q <= 1'b1;
         awAddr_q <= '0;
      end else if (awHs) begin
         awReady_q <= 1'b0;
         awAddr_q <= s_axi_awaddr;
      end else if (bValid_q && s_axi_bready) begin
         awReady_q <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         wReady_q <= 1'b1;
         wData_q <= '0;
         wStrb_q <= '0;
      end else if (wHs) begin
         wReady_q <= 1'b0;
         wData_q <= s_axi_wdata[DATA_W-1:0];
         wStrb_q <= s_axi_wstrb[1:0];
      end else if (bValid_q && s_axi_bready) begin
         wReady_q <= 1'b1;
      end
   end

   // blocked writes still answer okay; they are silently dropped
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         bValid_q <= 1'b0;
         bResp_q <= RESP_OKAY;
      end else if (wrFire) begin
         bValid_q <= 1'b1;
         bResp_q <= (|wrHit) ? RESP_OKAY : RESP_DECERR;
      end else if (bValid_q && s_axi_bready) begin
         bValid_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   for (genvar g = 0; g < REG_N; g++) begin : gReg
      logic [DATA_W-1:0] nxt_d;
      always_comb begin
         nxt_d = regs_q[g];
         if (wStrb_q[0]) begin
            nxt_d[7:0] = wData_q[7:0];
         end
         if (wStrb_q[1]) begin
            nxt_d[15:8] = wData_q[15:8];
         end
         // the selected oscillator cannot be switched off
         if (g == SLOT_CLKSRC) begin
            if (nxt_d[CLK_SEL_BIT]) begin
               nxt_d[OSC2_OFF_BIT] = 1'b0; // [R8]
            end else begin
               nxt_d[OSC1_OFF_BIT] = 1'b0; // [R8]
            end
         end
      end
      always_ff @(posedge sys_clk) begin
         if (!nrst) begin
            regs_q[g] <= REG_RST;
         end else if (wrEn && wrHit[g] && REG_WR[g]) begin
            regs_q[g] <= nxt_d; // [R11] [R12]
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         osc1En_q <= 1'b1; // [R7]
         osc2En_q <= 1'b1; // [R7]
         clkSel_q <= 1'b0; // [R7]
      end else begin
         osc1En_q <= !regs_q[SLOT_CLKSRC][OSC1_OFF_BIT]; // [R8]
         osc2En_q <= !regs_q[SLOT_CLKSRC][OSC2_OFF_BIT]; // [R8]
         clkSel_q <= regs_q[SLOT_CLKSRC][CLK_SEL_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////
   assign rdHit = decode(s_axi_araddr);

   always_comb begin
      status = '0;
      status[STAT_UNLOCK_BIT] = unlocked_q;
      status[STAT_STRAP_BIT] = strap_q;
      status[STAT_PWR_BIT] = monIf.powerUpDone;
      rdVal = '0;
      for (int i = 0; i < REG_N; i++) begin
         if (rdHit[i]) begin
            rdVal = (i == SLOT_STAT) ? status : regs_q[i];
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         arReady_q <= 1'b1;
         rValid_q <= 1'b0;
         rData_q <= '0;
         rResp_q <= RESP_OKAY;
      end else if (arHs) begin
         arReady_q <= 1'b0;
         rValid_q <= 1'b1;
         rData_q <= rdVal;
         rResp_q <= (|rdHit) ? RESP_OKAY : RESP_DECERR;
      end else if (rValid_q && s_axi_rready) begin
         arReady_q <= 1'b1;
         rValid_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   assign s_axi_awready = awReady_q;
   assign s_axi_wready = wReady_q;
   assign s_axi_bvalid = bValid_q;
   assign s_axi_bresp = bResp_q;
   assign s_axi_arready = arReady_q;
   assign s_axi_rvalid = rValid_q;
   assign s_axi_rresp = rResp_q;
   assign s_axi_rdata = {16'h0000, rData_q};
   assign deviceResetPinOut = pinOut_q;
   assign deviceResetPinOe = pinOe_q;
   assign deviceRst = devRst_q;
   assign cpuOutputClock = cpuOut_q;
   assign osc1Enable = osc1En_q;
   assign osc2Enable = osc2En_q;
   assign clkSrcSel = clkSel_q;
   assign osc1Trim = regs_q[SLOT_OSC1TRIM]; // [R9]
   assign osc2Trim = regs_q[SLOT_OSC2TRIM]; // [R9]

   ////////////////////////////////////////////////////////////////////
   property p_pin_low;
      monIf.supplyRst |=> deviceResetPinOe && !deviceResetPinOut;
   endproperty
   a_pin_low: assert property (p_pin_low) // [R1]
      else $error("reset pin not pulled while supply low");

   property p_dev_rst;
      monIf.supplyRst || watchdogReset |=> deviceRst;
   endproperty
   a_dev_rst: assert property (p_dev_rst) // [R13]
      else $error("device reset missing for an active source");

   property p_dev_free;
      !monIf.supplyRst && !watchdogReset && syncB_q[SY_PIN]
         |=> !deviceRst;
   endproperty
   a_dev_free: assert property (p_dev_free) // [R13]
      else $error("device reset held with all sources idle");

   property p_strap_static;
      monIf.powerUpDone && $past(monIf.powerUpDone) |-> $stable(strap_q);
   endproperty
   a_strap_static: assert property (p_strap_static) // [R5]
      else $error("strap changed after power-up");

   sequence s_locked_write;
      wrFire && !unlocked_q && wrHit[SLOT_CLKSRC];
   endsequence
   property p_blocked;
      s_locked_write |=> $stable(regs_q[SLOT_CLKSRC]) ##1 $stable(osc1En_q);
   endproperty
   a_blocked: assert property (p_blocked) // [R11]
      else $error("protected write took effect while locked");

   sequence s_unlock;
      writeProtectUnlock && !writeProtectLock;
   endsequence
   property p_unlock_lock;
      s_unlock ##1 writeProtectLock |=> !unlocked_q;
   endproperty
   a_unlock_lock: assert property (p_unlock_lock) // [R12]
      else $error("lock did not block writes again");

   property p_unlock_open;
      s_unlock |=> unlocked_q;
   endproperty
   a_unlock_open: assert property (p_unlock_open) // [R12]
      else $error("unlock did not open writes");

   property p_osc_off;
      wrEn && wrHit[SLOT_CLKSRC] && wStrb_q[0] &&
         wData_q[OSC2_OFF_BIT] && !wData_q[CLK_SEL_BIT]
         |-> ##2 !osc2Enable && osc1Enable;
   endproperty
   a_osc_off: assert property (p_osc_off) // [R8]
      else $error("unused oscillator not powered down");

   property p_defaults;
      $rose(nrst) |-> osc1Enable && osc2Enable && !clkSrcSel;
   endproperty
   a_defaults: assert property (p_defaults) // [R7]
      else $error("oscillator defaults wrong after reset");

   property p_trim;
      wrEn && wrHit[SLOT_OSC1TRIM] && wStrb_q == 2'h3
         |=> osc1Trim == $past(wData_q);
   endproperty
   a_trim: assert property (p_trim) // [R9]
      else $error("trim output does not follow its register");

   property p_clk_follow;
      $rose(syncB_q[SY_CLK]) |=> cpuOutputClock;
   endproperty
   a_clk_follow: assert property (p_clk_follow) // [R10]
      else $error("output clock edge missing");
endmodule : sro_supply_reset_ctrl

// ===== tb/sro_supply_reset_ctrl_bench.sv
`timescale 1ns/100ps
module sro_supply_reset_ctrl_bench import sro_pkg::*;;
   logic sys_clk, nrst;
   logic [31:0] awAddr, wData, arAddr, rData;
   logic [3:0] wStrb;
   logic awValid, awReady, wValid, wReady, bValid, bReady;
   logic arValid, arReady, rValid, rReady;
   logic [1:0] bResp, rResp;
   // pins: 0 por core, 1 por io, 2 bor core, 3 bor io
   logic [3:0] lowPins;
   logic regDisPin, rstWire, rstOut, rstOe, cpuInClk, cpuOutClk;
   logic wdogRst, unlockP, lockP, deviceRst, osc1En, osc2En, clkSel;
   logic [DATA_W-1:0] osc1Trim, osc2Trim;
   logic [DATA_W-1:0] mdl [REG_N];
   logic mdlUnlocked, mdlStrap;
   logic [31:0] seed;
   int error_cnt, samples_checked, waitCyc, inEdges, outEdges;

   // open-drain reset wire with pull-up
   assign rstWire = rstOe ? rstOut : 1'b1;

   sro_supply_reset_ctrl #(.ADDR_W(32)) sro_supply_reset_ctrl_inst (
      .sys_clk(sys_clk), .nrst(nrst),
      .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
      .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
      .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
      .s_axi_bvalid(bValid), .s_axi_bready(bReady),
      .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
      .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
      .s_axi_rvalid(rValid), .s_axi_rready(rReady),
      .porCoreLowPin(lowPins[0]), .porIoLowPin(lowPins[1]),
      .borCoreLowPin(lowPins[2]), .borIoLowPin(lowPins[3]),
      .regulatorDisablePin(regDisPin), .deviceResetPinIn(rstWire),
      .deviceResetPinOut(rstOut), .deviceResetPinOe(rstOe),
      .cpuInputClock(cpuInClk), .cpuOutputClock(cpuOutClk),
      .watchdogReset(wdogRst), .writeProtectUnlock(unlockP),
      .writeProtectLock(lockP), .deviceRst(deviceRst),
      .osc1Enable(osc1En), .osc2Enable(osc2En), .clkSrcSel(clkSel),
      .osc1Trim(osc1Trim), .osc2Trim(osc2Trim));

   ////////////////////////////////////////////////////////////////////////
   initial begin
      sys_clk = 1'b0;
      forever #(CLK_NS / 2) sys_clk = ~sys_clk;
   end
   always @(posedge cpuInClk) inEdges++;
   always @(posedge cpuOutClk) outEdges++;
   initial begin
      repeat (100000) @(posedge sys_clk);
      fail("timeout");
   end

   ////////////////////////////////////////////////////////////////////////
   task conclude;
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : conclude

   task check(input logic [31:0] got, input logic [31:0] exp,
         input string msg);
      samples_checked++;
      if (got !== exp) begin
         $display("[ERR] %0t %s", $time, msg);
         error_cnt++;
      end
   endtask : check

   task fail(input string msg);
      check(32'h1, 32'h0, msg);
      conclude();
   endtask : fail

   function logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   function logic [31:0] adr(input int s);
      return {14'h0, REG_IDX[s], 2'b00};
   endfunction : adr

   task axiWr(input logic [31:0] a, input logic [31:0] d,
         output logic [1:0] r);
      int n;
      n = 0;
      @(posedge sys_clk);
      awAddr <= a;
      wData <= d;
      wStrb <= 4'hF;
      awValid <= 1'b1;
      wValid <= 1'b1;
      bReady <= 1'b1;
      forever begin
         @(posedge sys_clk);
         if (awValid && awReady) awValid <= 1'b0;
         if (wValid && wReady) wValid <= 1'b0;
         if (bValid) begin
            r = bResp;
            bReady <= 1'b0;
            break;
         end
         if (++n > 50) fail("write hang");
      end
   endtask : axiWr

   task axiRd(input logic [31:0] a, output logic [31:0] d,
         output logic [1:0] r);
      int n;
      n = 0;
      @(posedge sys_clk);
      arAddr <= a;
      arValid <= 1'b1;
      rReady <= 1'b1;
      forever begin
         @(posedge sys_clk);
         if (arValid && arReady) arValid <= 1'b0;
         if (rValid) begin
            d = rData;
            r = rResp;
            rReady <= 1'b0;
            break;
         end
         if (++n > 50) fail("read hang");
      end
   endtask : axiRd

   // model only changes what an unlocked, writable slot would accept
   task wrSlot(input int s, input logic [31:0] d);
      logic [1:0] r;
      axiWr(adr(s), d, r);
      check(r, RESP_OKAY, "bresp");
      if (REG_WR[s] && mdlUnlocked) begin
         mdl[s] = d[15:0];
         if (s == SLOT_CLKSRC) begin
            mdl[s][OSC1_OFF_BIT + int'(mdl[s][CLK_SEL_BIT])] = 1'b0;
         end
      end
   endtask : wrSlot

   task sweep(input bit doWr);
      logic [31:0] d;
      logic [1:0] r;
      logic [15:0] e;
      for (int s = 0; s < REG_N; s++) begin
         if (doWr) wrSlot(s, xs());
         axiRd(adr(s), d, r);
         e = (s == SLOT_STAT) ? {13'h0, 1'b1, mdlStrap, mdlUnlocked} : mdl[s];
         check(d, {16'h0, e}, "readback");
      end
      repeat (2) @(negedge sys_clk);
      check(osc1En, !mdl[SLOT_CLKSRC][OSC1_OFF_BIT], "osc1 en");
      check(osc2En, !mdl[SLOT_CLKSRC][OSC2_OFF_BIT], "osc2 en");
      check(clkSel, mdl[SLOT_CLKSRC][CLK_SEL_BIT], "clk sel");
      check(osc1Trim, mdl[SLOT_OSC1TRIM], "trim1");
      check(osc2Trim, mdl[SLOT_OSC2TRIM], "trim2");
   endtask : sweep

   task waitSig(input bit rel, input int bound);
      for (waitCyc = 0; waitCyc < bound; waitCyc++) begin
         @(negedge sys_clk);
         if (rel ? (deviceRst === 1'b0 && rstOe === 1'b0)
               : rstOe === 1'b1) return;
      end
      fail("reset wait");
   endtask : waitSig

   task quiet(input int n);
      repeat (n) begin
         @(negedge sys_clk);
         check(rstOe, 1'b0, "spurious reset");
      end
   endtask : quiet

   task pulse(input bit unl);
      @(posedge sys_clk);
      if (unl) unlockP <= 1'b1;
      else lockP <= 1'b1;
      @(posedge sys_clk);
      unlockP <= 1'b0;
      lockP <= 1'b0;
      mdlUnlocked = unl;
   endtask : pulse

   task powerUp(input logic strap);
      @(posedge sys_clk);
      nrst <= 1'b0;
      regDisPin <= strap;
      foreach (mdl[i]) mdl[i] = REG_RST;
      mdlUnlocked = 1'b0;
      mdlStrap = strap;
      repeat (5) @(posedge sys_clk);
      @(negedge sys_clk);
      check(rstOe, 1'b1, "oe in reset");
      check(rstWire, 1'b0, "pin not low");
      check(deviceRst, 1'b1, "rst in reset");
      check({osc1En, osc2En, clkSel}, 3'b110, "osc at reset");
      repeat (5) @(posedge sys_clk);
      nrst <= 1'b1;
      waitSig(1'b1, 300);
      check(32'(waitCyc >= POR_HOLD_CYC), 32'h1, "hold short");
   endtask : powerUp

   ////////////////////////////////////////////////////////////////////////
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      {nrst, awValid, wValid, bReady, arValid, rReady} = '0;
      {awAddr, wData, arAddr, wStrb, lowPins} = '0;
      {regDisPin, cpuInClk, wdogRst, unlockP, lockP} = '0;
      error_cnt = 0;
      samples_checked = 0;
      seed = 32'h694C;
      powerUp(1'b0);
      sweep(1'b0);
      sweep(1'b1);
      pulse(1'b1);
      sweep(1'b1);
      axiRd(32'h0000_0000, d, r);
      check(r, RESP_DECERR, "unmapped resp");
      check(d, 32'h0, "unmapped data");
      axiWr(adr(0) + 32'h1, 32'h0000_FFFF, r);
      check(r, RESP_DECERR, "misaligned write");
      wrSlot(SLOT_BROWN, 32'h0);
      // both off asked with osc one selected: only osc two may stop
      wrSlot(SLOT_CLKSRC, 32'h6);
      for (int i = 0; i < 4; i++) begin
         @(posedge sys_clk) lowPins[i] <= 1'b1;
         waitSig(1'b0, 10);
         @(negedge sys_clk);
         check(deviceRst, 1'b1, "supply rst");
         @(posedge sys_clk) lowPins[i] <= 1'b0;
         waitSig(1'b1, 300);
      end
      wrSlot(SLOT_BROWN, 32'h1 << BROWN_DIS_BIT);
      @(posedge sys_clk) lowPins <= 4'b1100;
      quiet(20);
      @(posedge sys_clk) lowPins[1] <= 1'b1;
      waitSig(1'b0, 10);
      @(posedge sys_clk) lowPins <= 4'b0000;
      waitSig(1'b1, 300);
      wrSlot(SLOT_BROWN, 32'h0);
      // unlock directly followed by lock must end locked
      @(posedge sys_clk) unlockP <= 1'b1;
      @(posedge sys_clk) begin
         unlockP <= 1'b0;
         lockP <= 1'b1;
      end
      @(posedge sys_clk) lockP <= 1'b0;
      mdlUnlocked = 1'b0;
      wrSlot(SLOT_BROWN, 32'h1);
      sweep(1'b0);
      @(posedge sys_clk) lowPins[3] <= 1'b1;
      waitSig(1'b0, 10);
      @(posedge sys_clk) lowPins[3] <= 1'b0;
      waitSig(1'b1, 300);
      @(posedge sys_clk) wdogRst <= 1'b1;
      repeat (2) @(negedge sys_clk);
      check(deviceRst, 1'b1, "wdog rst");
      @(posedge sys_clk) wdogRst <= 1'b0;
      repeat (3) @(negedge sys_clk);
      check(deviceRst, 1'b0, "wdog release");
      inEdges = 0;
      outEdges = 0;
      repeat (40) begin
         repeat (3) @(posedge sys_clk);
         cpuInClk <= ~cpuInClk;
      end
      repeat (8) @(posedge sys_clk);
      check(outEdges, inEdges, "cpu clock");
      // strap is only taken during power-up, so a new reset is needed
      powerUp(1'b1);
      sweep(1'b0);
      @(posedge sys_clk) lowPins[2] <= 1'b1;
      quiet(20);
      @(posedge sys_clk) lowPins[3] <= 1'b1;
      waitSig(1'b0, 10);
      @(posedge sys_clk) lowPins <= 4'b0000;
      waitSig(1'b1, 300);
      conclude();
   end
endmodule : sro_supply_reset_ctrl_bench
